// file: asfp_pkg.sv
// Notes on behaviour
// - host drives the serial shift clock
// - host lowers read frame sync to read
// - device shifts sixteen bits on rising edges
// - host holds write frame sync during writes
// - host presents six bits at rising edges, taken by the device at falling edges
// - conversion done is a low pulse
// - low standby input blocks new conversions
// - host start rate is 16 MHz over N
// - unreachable rate rounds to next lower
// - start rate up to 500 ksps sustained
// - rising convert start begins a conversion
package asfp_pkg;
  // ----------------------------------------
  // frame sizes and timing
  // ----------------------------------------
  localparam int unsigned RD_BITS = 16;
  localparam int unsigned WR_BITS = 6;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned GEN_MHZ = 16;
  localparam int unsigned MAX_KSPS = 500;
  // link clock half period in system cycles (host divider)
  localparam logic [3:0] SCLK_HALF = 4'h4;
  // divider count at which the host acts: two cycles after each fall
  localparam logic [3:0] SMP_CNT = 4'h1;
  // conversion time in system cycles and done pulse width
  localparam logic [7:0] CONV_CYC = 8'h40;
  localparam logic [3:0] DONE_CYC = 4'h4;
  // start pulse high width in system cycles
  localparam logic [3:0] START_HI = 4'h4;
  // shortest start period in cycles: 250 MHz / 500 ksps
  localparam int unsigned MIN_PER = (CLK_MHZ * 1000) / MAX_KSPS;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [5:0] CTRL_RST = 6'h00;
endpackage

// file: asfp_if.sv
`timescale 1ns/1ns
// ----------------------------------------
// serial link between host and converter
// ----------------------------------------
interface asfp_if;
  logic sclk;
  logic read_frame_sync_n;
  logic write_frame_sync_n;
  logic data_in;
  logic data_out;
  logic conv_done_n;
  logic convert_start;
  logic standby_n;
  modport dev (input sclk, input read_frame_sync_n, input write_frame_sync_n,
    input data_in, input convert_start, input standby_n,
    output data_out, output conv_done_n);
  modport host (output sclk, output read_frame_sync_n, output write_frame_sync_n,
    output data_in, output convert_start, output standby_n,
    input data_out, input conv_done_n);
endinterface

// file: asfp_sync.sv
`timescale 1ns/1ns
// ----------------------------------------
// two-flop synchroniser with edge detect
// ----------------------------------------
module asfp_sync (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // pin in, synced level and edges out
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_q, meta_d, sync_q, sync_d, last_q, last_d;
  // the first flop feeds only the second
  always_comb
  begin
    meta_d = pin;
    sync_d = meta_q;
    last_d = sync_q;
  end
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end
  assign level = sync_q;
  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;
endmodule

// file: asfp_dev.sv
`timescale 1ns/1ns
// ----------------------------------------
// converter end: conversion timing, serial shifter
// ----------------------------------------
module asfp_dev (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // link
  asfp_if.dev lnk,
  // sample source and control bits out
  input wire logic [11:0] sample,
  output logic [5:0] ctrl_word,
  output logic ctrl_valid,
  output logic standby
);
  logic sclk_r, sclk_f, rfs_r, rfs_f, wfs_s, wfs_f, din_s, cs_r, sb_s;
  asfp_sync u_sclk (.sys_clk(sys_clk), .rst_n(rst_n), .pin(lnk.sclk),
    .level(), .rise(sclk_r), .fall(sclk_f));
  asfp_sync u_rfs (.sys_clk(sys_clk), .rst_n(rst_n), .pin(lnk.read_frame_sync_n),
    .level(), .rise(rfs_r), .fall(rfs_f));
  asfp_sync u_wfs (.sys_clk(sys_clk), .rst_n(rst_n), .pin(lnk.write_frame_sync_n),
    .level(wfs_s), .rise(), .fall(wfs_f));
  asfp_sync u_din (.sys_clk(sys_clk), .rst_n(rst_n), .pin(lnk.data_in),
    .level(din_s), .rise(), .fall());
  asfp_sync u_cs (.sys_clk(sys_clk), .rst_n(rst_n), .pin(lnk.convert_start),
    .level(), .rise(cs_r), .fall());
  asfp_sync u_sb (.sys_clk(sys_clk), .rst_n(rst_n), .pin(lnk.standby_n),
    .level(sb_s), .rise(), .fall());

  typedef enum logic [2:0] {
    ASFP_IDLE = 3'b001,
    ASFP_CONV = 3'b010,
    ASFP_DONE = 3'b100
  } asfp_cst_t;
  asfp_cst_t st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic [15:0] res_q, res_d, sh_q, sh_d;
  logic [4:0] rbit_q, rbit_d;
  logic [2:0] wbit_q, wbit_d;
  logic [5:0] wsh_q, wsh_d, ctrl_q, ctrl_d;
  logic cv_q, cv_d, dout_q, dout_d, done_n_q, done_n_d, sb_q, sb_d, rd_q, rd_d;

  // ----------------------------------------
  // conversion, serial read and write
  // ----------------------------------------
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    res_d = res_q;
    done_n_d = 1'b1; // line rests high
    sb_d = ~sb_s;
    sh_d = sh_q;
    rbit_d = rbit_q;
    rd_d = rd_q;
    dout_d = dout_q;
    wbit_d = wbit_q;
    wsh_d = wsh_q;
    ctrl_d = ctrl_q;
    cv_d = 1'b0;
    case (st_q)
      ASFP_IDLE:
      begin
        // standby blocks new conversions but not serial access
        if (cs_r && sb_s)
        begin
          st_d = ASFP_CONV;
          cnt_d = asfp_pkg::CONV_CYC;
        end
      end
      ASFP_CONV:
      begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h01)
        begin
          res_d = {4'h0, sample};
          st_d = ASFP_DONE;
          cnt_d = {4'h0, asfp_pkg::DONE_CYC};
        end
      end
      ASFP_DONE:
      begin
        done_n_d = 1'b0;
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h01)
          st_d = ASFP_IDLE;
      end
      default: st_d = ASFP_IDLE;
    endcase
    // frame start loads the result; first bit goes out on the first rising edge
    if (rfs_f)
    begin
      sh_d = res_q;
      rbit_d = 5'h00;
      rd_d = 1'b1;
    end
    else if (rd_q && sclk_r)
    begin
      dout_d = sh_q[15];
      sh_d = {sh_q[14:0], 1'b0};
      rbit_d = rbit_q + 5'h01;
      if (rbit_q == 5'(asfp_pkg::RD_BITS - 1))
        rd_d = 1'b0;
    end
    if (rfs_r)
      rd_d = 1'b0;
    // control bits taken on falling edges while write sync is low
    if (wfs_f)
      wbit_d = 3'h0;
    else if (!wfs_s && sclk_f && wbit_q < 3'(asfp_pkg::WR_BITS))
    begin
      wsh_d = {wsh_q[4:0], din_s};
      wbit_d = wbit_q + 3'h1;
      if (wbit_q == 3'(asfp_pkg::WR_BITS - 1))
      begin
        ctrl_d = {wsh_q[4:0], din_s};
        cv_d = 1'b1;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= ASFP_IDLE;
      cnt_q <= 8'h00;
      res_q <= asfp_pkg::RESULT_RST;
      done_n_q <= 1'b1;
      sb_q <= 1'b0;
      sh_q <= 16'h0000;
      rbit_q <= 5'h00;
      rd_q <= 1'b0;
      dout_q <= 1'b0;
      wbit_q <= 3'(asfp_pkg::WR_BITS);
      wsh_q <= 6'h00;
      ctrl_q <= asfp_pkg::CTRL_RST;
      cv_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      res_q <= res_d;
      done_n_q <= done_n_d;
      sb_q <= sb_d;
      sh_q <= sh_d;
      rbit_q <= rbit_d;
      rd_q <= rd_d;
      dout_q <= dout_d;
      wbit_q <= wbit_d;
      wsh_q <= wsh_d;
      ctrl_q <= ctrl_d;
      cv_q <= cv_d;
    end
  end
  assign lnk.data_out = dout_q;
  assign lnk.conv_done_n = done_n_q;
  assign ctrl_word = ctrl_q;
  assign ctrl_valid = cv_q;
  assign standby = sb_q;
endmodule

// file: asfp_host.sv
`timescale 1ns/1ns
// ----------------------------------------
// host end: start generator, clock and frames
// ----------------------------------------
module asfp_host (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // link
  asfp_if.host lnk,
  // user side
  input wire logic [16:0] divide_n,
  input wire logic gen_en,
  input wire logic [5:0] ctrl_word,
  input wire logic ctrl_req,
  input wire logic standby_req,
  output logic [15:0] result,
  output logic result_valid,
  output logic busy
);
  logic done_r, dout_s;
  asfp_sync u_done (.sys_clk(sys_clk), .rst_n(rst_n), .pin(lnk.conv_done_n),
    .level(), .rise(done_r), .fall());
  asfp_sync u_dout (.sys_clk(sys_clk), .rst_n(rst_n), .pin(lnk.data_out),
    .level(dout_s), .rise(), .fall());

  typedef enum logic [2:0] {
    ASFP_H_IDLE = 3'b001,
    ASFP_H_READ = 3'b010,
    ASFP_H_WRITE = 3'b100
  } asfp_hst_t;
  asfp_hst_t st_q, st_d;
  logic [19:0] gacc_q, gacc_d, per_q, per_d;
  logic cs_q, cs_d;
  logic [3:0] hcnt_q, hcnt_d;
  logic sclk_q, sclk_d, rfs_q, rfs_d, wfs_q, wfs_d, din_q, din_d, sb_q, sb_d;
  logic [4:0] bit_q, bit_d;
  logic [15:0] sh_q, sh_d, res_q, res_d;
  logic [5:0] wsh_q, wsh_d;
  logic rv_q, rv_d, pend_q, pend_d;
  logic [19:0] per_raw;
  logic rise_ev, fall_ev, tick, busy_q, busy_d;

  // link clock phases; the tick sits two cycles after each fall, when the bit
  // that stood at data_out on that fall has come through our synchroniser
  assign rise_ev = (hcnt_q == asfp_pkg::SCLK_HALF - 4'h1) && !sclk_q;
  assign fall_ev = (hcnt_q == asfp_pkg::SCLK_HALF - 4'h1) && sclk_q;
  assign tick = (hcnt_q == asfp_pkg::SMP_CNT) && !sclk_q;

  // 16 MHz/N, N=0 read as 1; 250/16 is not whole so the period
  // in system cycles is rounded up, giving the next lower rate
  always_comb
  begin
    per_raw = 20'((64'(divide_n == 17'h00000 ? 17'h00001 : divide_n) * asfp_pkg::CLK_MHZ
      + asfp_pkg::GEN_MHZ - 1) / asfp_pkg::GEN_MHZ);
    // never faster than the sustained sample rate
    if (per_raw < 20'(asfp_pkg::MIN_PER))
      per_raw = 20'(asfp_pkg::MIN_PER);
  end

  // ----------------------------------------
  // start generator, serial clock, frames
  // ----------------------------------------
  always_comb
  begin
    per_d = per_raw;
    gacc_d = gacc_q;
    cs_d = cs_q;
    if (gen_en)
    begin
      gacc_d = gacc_q + 20'h00001;
      if (gacc_q + 20'h00001 >= per_q)
        gacc_d = 20'h00000;
      cs_d = gacc_q < 20'(asfp_pkg::START_HI);
    end
    else
    begin
      gacc_d = 20'h00000;
      cs_d = 1'b0;
    end
    sb_d = ~standby_req;
    st_d = st_q;
    hcnt_d = hcnt_q;
    sclk_d = sclk_q;
    rfs_d = rfs_q;
    wfs_d = wfs_q;
    din_d = din_q;
    bit_d = bit_q;
    sh_d = sh_q;
    res_d = res_q;
    wsh_d = wsh_q;
    rv_d = 1'b0;
    pend_d = pend_q | done_r;
    // free-running divider; edges act only inside a frame
    hcnt_d = hcnt_q + 4'h1;
    if (hcnt_q == asfp_pkg::SCLK_HALF - 4'h1)
    begin
      hcnt_d = 4'h0;
      sclk_d = ~sclk_q;
    end
    case (st_q)
      ASFP_H_IDLE:
      begin
        // frames open mid-low, so the first rise comes after the sync edge
        if (tick)
        begin
          if (ctrl_req)
          begin
            st_d = ASFP_H_WRITE;
            wfs_d = 1'b0;
            wsh_d = ctrl_word;
            bit_d = 5'h00;
          end
          else if (pend_q)
          begin
            st_d = ASFP_H_READ;
            rfs_d = 1'b0;
            pend_d = done_r;
            bit_d = 5'h00;
          end
        end
      end
      ASFP_H_READ:
      begin
        // take the bit that stood at data_out on our last falling edge
        if (tick)
        begin
          sh_d = {sh_q[14:0], dout_s};
          bit_d = bit_q + 5'h01;
          if (bit_q == 5'(asfp_pkg::RD_BITS - 1))
          begin
            st_d = ASFP_H_IDLE;
            rfs_d = 1'b1;
            res_d = {sh_q[14:0], dout_s};
            rv_d = 1'b1;
          end
        end
      end
      ASFP_H_WRITE:
      begin
        // present bit on rising edge so it is stable at the falling edge
        if (rise_ev)
        begin
          din_d = wsh_q[5];
          wsh_d = {wsh_q[4:0], 1'b0};
        end
        if (fall_ev)
          bit_d = bit_q + 5'h01;
        // release only once the sixth fall has reached the device ahead of the sync
        if (tick && bit_q == 5'(asfp_pkg::WR_BITS))
        begin
          st_d = ASFP_H_IDLE;
          wfs_d = 1'b1;
        end
      end
      default: st_d = ASFP_H_IDLE;
    endcase
    // busy is registered so the output comes straight from a flop
    busy_d = (st_d != ASFP_H_IDLE);
  end
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      per_q <= 20'(asfp_pkg::MIN_PER);
      gacc_q <= 20'h00000;
      cs_q <= 1'b0;
      sb_q <= 1'b1;
      st_q <= ASFP_H_IDLE;
      hcnt_q <= 4'h0;
      sclk_q <= 1'b0;
      rfs_q <= 1'b1;
      wfs_q <= 1'b1;
      din_q <= 1'b0;
      bit_q <= 5'h00;
      sh_q <= 16'h0000;
      res_q <= 16'h0000;
      wsh_q <= 6'h00;
      rv_q <= 1'b0;
      pend_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      per_q <= per_d;
      gacc_q <= gacc_d;
      cs_q <= cs_d;
      sb_q <= sb_d;
      st_q <= st_d;
      hcnt_q <= hcnt_d;
      sclk_q <= sclk_d;
      rfs_q <= rfs_d;
      wfs_q <= wfs_d;
      din_q <= din_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      res_q <= res_d;
      wsh_q <= wsh_d;
      rv_q <= rv_d;
      pend_q <= pend_d;
      busy_q <= busy_d;
    end
  end
  assign lnk.sclk = sclk_q;
  assign lnk.read_frame_sync_n = rfs_q;
  assign lnk.write_frame_sync_n = wfs_q;
  assign lnk.data_in = din_q;
  assign lnk.convert_start = cs_q;
  assign lnk.standby_n = sb_q;
  assign result = res_q;
  assign result_valid = rv_q;
  assign busy = busy_q;
endmodule

// file: asfp_properties.sv
`timescale 1ns/1ns
module asfp_properties (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // link wires
  input wire logic sclk,
  input wire logic read_frame_sync_n,
  input wire logic write_frame_sync_n,
  input wire logic data_in,
  input wire logic data_out,
  input wire logic conv_done_n,
  input wire logic convert_start,
  input wire logic standby_n
);
  logic [15:0] age_q, age_d;
  logic [4:0] rd_q, rd_d, wr_q, wr_d;
  logic [3:0] p_q;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // ------------------------------
  // helper counters
  // ------------------------------
  // age saturates so a long idle never wraps into a short gap
  always_comb
  begin
    age_d = (age_q == 16'hFFFF) ? age_q : age_q + 16'h0001;
    if (convert_start && !p_q[3])
      age_d = 16'h0000;
    rd_d = rd_q + 5'(!sclk && p_q[2] && !p_q[1]);
    if (!read_frame_sync_n && p_q[1])
      rd_d = 5'h00;
    wr_d = wr_q + 5'(!sclk && p_q[2] && !p_q[0]);
    if (!write_frame_sync_n && p_q[0])
      wr_d = 5'h00;
  end
  // counter registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      age_q <= 16'hFFFF;
      rd_q <= 5'h00;
      wr_q <= 5'h00;
      p_q <= 4'h3;
    end
    else
    begin
      age_q <= age_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      p_q <= {convert_start, sclk, read_frame_sync_n, write_frame_sync_n};
    end
  end
  // ------------------------------
  // properties
  // ------------------------------
  done_width_a:
    assert property ($fell(conv_done_n) |-> !conv_done_n [*4] ##1 conv_done_n)
    else $error("done pulse width wrong");
  done_latency_a:
    assert property ($fell(conv_done_n) |-> age_q >= 16'h0040 && age_q <= 16'h0050)
    else $error("done not tied to a start");
  start_done_a:
    assert property ($rose(convert_start) && standby_n |-> ##[64:80] $fell(conv_done_n))
    else $error("start gave no done");
  start_spacing_a:
    assert property ($rose(convert_start) |-> age_q >= 16'h01F3)
    else $error("starts too close");
  read_count_a:
    assert property ($rose(read_frame_sync_n) |-> rd_d == 5'h10)
    else $error("read frame bit count wrong");
  write_count_a:
    assert property ($rose(write_frame_sync_n) |-> wr_d == 5'h06)
    else $error("write frame bit count wrong");
  out_on_rise_a:
    assert property ($changed(data_out) && !read_frame_sync_n |-> $past(sclk))
    else $error("data out moved off rising edge");
  out_hold_a:
    assert property ($fell(sclk) && !read_frame_sync_n |=> $stable(data_out))
    else $error("data out moved at falling edge");
endmodule

// file: adc_serial_frame_port_tb.sv
`timescale 1ns/1ns
module adc_serial_frame_port_tb;
  logic sys_clk, rst_n, gen_en, ctrl_req, standby_req;
  logic ctrl_valid, standby, result_valid, busy, st_prev;
  logic [11:0] sample;
  logic [16:0] divide_n;
  logic [5:0] ctrl_in, ctrl_word;
  logic [15:0] result, st_age, st_per;
  int num_errors;
  int samples_checked;
  asfp_if lnk ();
  asfp_dev asfp_dev_inst (.sys_clk(sys_clk), .rst_n(rst_n), .lnk(lnk), .sample(sample),
    .ctrl_word(ctrl_word), .ctrl_valid(ctrl_valid), .standby(standby));
  asfp_host asfp_host_inst (.sys_clk(sys_clk), .rst_n(rst_n), .lnk(lnk),
    .divide_n(divide_n), .gen_en(gen_en), .ctrl_word(ctrl_in), .ctrl_req(ctrl_req),
    .standby_req(standby_req), .result(result), .result_valid(result_valid), .busy(busy));
  asfp_properties asfp_properties_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .sclk(lnk.sclk), .read_frame_sync_n(lnk.read_frame_sync_n),
    .write_frame_sync_n(lnk.write_frame_sync_n), .data_in(lnk.data_in),
    .data_out(lnk.data_out), .conv_done_n(lnk.conv_done_n),
    .convert_start(lnk.convert_start), .standby_n(lnk.standby_n));
  // ------------------------------
  // helpers
  // ------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // steps one edge first, so a pulse already seen is not seen twice
  task automatic wait_on(ref logic s, input logic lvl);
    int n;
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (s !== lvl && n < 4000);
    // a wait that runs out counts as a failure of its own
    if (s !== lvl)
    begin
      num_errors++;
      $display("mismatch wait_on expected %b seen %b", lvl, s);
    end
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // rise-to-rise spacing of generated starts
  always @(negedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_prev <= 1'b0;
      st_age <= 16'h0000;
      st_per <= 16'h0000;
    end
    else
    begin
      st_prev <= lnk.convert_start;
      st_age <= (lnk.convert_start && !st_prev) ? 16'h0001 : st_age + 16'h0001;
      if (lnk.convert_start && !st_prev)
        st_per <= st_age;
    end
  end
  // ------------------------------
  // scenarios
  // ------------------------------
  // generator idle here, so busy can only mean a write
  task automatic t_write(input logic [5:0] w);
    ctrl_in = w;
    ctrl_req = 1'b1;
    wait_on(busy, 1'b1);
    ctrl_req = 1'b0;
    wait_on(ctrl_valid, 1'b1);
    check("ctrl_valid", 16'(ctrl_valid), 16'h0001);
    check("ctrl_word", 16'(ctrl_word), 16'(w));
  endtask
  // third result is the first one fully under the new divider
  task automatic t_convert(input logic [11:0] smp, input logic [16:0] n);
    int p;
    p = int'((n == 17'h00000) ? 17'h00001 : n);
    p = (p * asfp_pkg::CLK_MHZ + asfp_pkg::GEN_MHZ - 1) / asfp_pkg::GEN_MHZ;
    if (p < asfp_pkg::MIN_PER)
      p = asfp_pkg::MIN_PER;
    sample = smp;
    divide_n = n;
    gen_en = 1'b1;
    repeat (3) wait_on(result_valid, 1'b1);
    check("result_valid", 16'(result_valid), 16'h0001);
    check("result", result, {4'h0, smp});
    check("start_period", st_per, 16'(p));
  endtask
  // park right after a readout; starts keep arriving while parked
  task automatic t_standby();
    int n;
    n = 0;
    wait_on(result_valid, 1'b1);
    standby_req = 1'b1;
    wait_on(standby, 1'b1);
    check("standby_on", 16'(standby), 16'h0001);
    repeat (2048)
    begin
      @(negedge sys_clk);
      n += int'(lnk.conv_done_n !== 1'b1);
    end
    check("parked_done", 16'(n), 16'h0000);
    standby_req = 1'b0;
    wait_on(standby, 1'b0);
    check("standby_off", 16'(standby), 16'h0000);
    wait_on(result_valid, 1'b1);
    check("resumed", result, {4'h0, sample});
  endtask
  // ------------------------------
  // clock, sequence, watchdog
  // ------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever
      #2 sys_clk = ~sys_clk;
  end
  initial
  begin
    num_errors = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    {gen_en, ctrl_req, standby_req} = 3'h0;
    sample = 12'h000;
    divide_n = 17'h00000;
    ctrl_in = 6'h00;
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    t_write(6'h2D);
    t_write(6'h3F);
    t_write(6'h00);
    t_convert(12'hFFF, 17'h00000);
    t_convert(12'h000, 17'h00021);
    t_convert(12'hA5A, 17'h00040);
    t_convert(12'h801, 17'h00001);
    t_standby();
    close_out();
  end
  // run needs about 11k cycles; this allows 50k
  initial
  begin
    #200000;
    num_errors++;
    close_out();
  end
endmodule
